/* design/erb_pkg.sv */
// Package: sizes, geometry and mode codes of the embedded RAM block
package erb_pkg;
  // Large RAM block geometry
  localparam int LRB_BITS       = 20480;
  localparam int LRB_WIDTH      = 20;
  localparam int LRB_DEPTH      = LRB_BITS / LRB_WIDTH;
  localparam int LRB_AW         = $clog2(LRB_DEPTH);
  // Logic-cluster RAM geometry
  localparam int LCR_MODULES    = 10;
  localparam int LCR_MOD_BITS   = 64;
  localparam int LCR_BITS       = LCR_MODULES * LCR_MOD_BITS;
  localparam int LCR_W_WIDE     = 20;
  localparam int LCR_D_WIDE     = 32;
  localparam int LCR_W_DEEP     = 10;
  localparam int LCR_D_DEEP     = 64;
  localparam int LCR_AW         = 6;
  localparam int LCR_DW         = 20;
  // Reset values
  localparam logic [LRB_WIDTH-1:0] LRB_OUT_RST = '0;
  localparam logic [LCR_DW-1:0]    LCR_OUT_RST = '0;
  // Value shown on an undefined read
  localparam logic [LCR_DW-1:0]    LCR_UNDEF   = 20'h00000;
  // Shape of the logic-cluster RAM
  typedef enum logic {ERB_SHAPE_32X20, ERB_SHAPE_64X10} erb_shape_t;
  // Cluster power mode
  typedef enum logic {ERB_PWR_HIGH_PERF, ERB_PWR_LOW} erb_pwr_t;
endpackage

/* design/erb_cluster_ram.sv */
// Logic-cluster RAM: ten 64-bit modules, 32x20 or 64x10 dual port
`timescale 1ns/1ps
module erb_cluster_ram (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_sys_rst,
  // Cluster clock gate and configuration
  input  wire logic                      i_cluster_clock_gate_one,
  input  wire erb_pkg::erb_shape_t       i_shape,
  // Write port
  input  wire logic                      i_wr_en,
  input  wire logic [erb_pkg::LCR_AW-1:0] i_wr_addr,
  input  wire logic [erb_pkg::LCR_DW-1:0] i_wr_data,
  // Read port
  input  wire logic                      i_rd_en,
  input  wire logic [erb_pkg::LCR_AW-1:0] i_rd_addr,
  output logic      [erb_pkg::LCR_DW-1:0] o_rd_data
);
  localparam int NM = erb_pkg::LCR_MODULES;
  localparam int MB = erb_pkg::LCR_MOD_BITS;

  typedef struct packed {
    logic [erb_pkg::LCR_DW-1:0] din;
    logic [erb_pkg::LCR_AW-1:0] waddr;
    logic                       wen;
    logic [erb_pkg::LCR_AW-1:0] raddr;
    logic                       ren;
    logic [erb_pkg::LCR_DW-1:0] dout;
  } erb_lcr_st_t;

  erb_lcr_st_t st_r;
  erb_lcr_st_t st_nxt;
  // Ten modules of 64 bits each, 640 bits in all
  logic [MB-1:0] mod_mem [NM];
  logic [erb_pkg::LCR_DW-1:0] rd_word;

  // Gated enable shared by every register of the cluster
  logic gate_en;
  assign gate_en = i_cluster_clock_gate_one;

  // Each module is 32x2 or 64x1 depending on shape
  always_comb begin
    rd_word = '0;
    for (int m = 0; m < NM; m++) begin
      if (i_shape == erb_pkg::ERB_SHAPE_32X20) begin
        rd_word[2*m]   = mod_mem[m][{st_r.raddr[4:0], 1'b0}];
        rd_word[2*m+1] = mod_mem[m][{st_r.raddr[4:0], 1'b1}];
      end else begin
        rd_word[m] = mod_mem[m][st_r.raddr];
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (gate_en) begin
      // Data in and write address held inside the block
      st_nxt.din   = i_wr_data;
      st_nxt.waddr = i_wr_addr;
      st_nxt.wen   = i_wr_en;
      // Read address taken from neighbouring logic registers
      st_nxt.raddr = i_rd_addr;
      st_nxt.ren   = i_rd_en;
      if (st_r.ren) begin
        // Same address collision: output must not be trusted
        if (st_r.wen && st_r.waddr == st_r.raddr)
          st_nxt.dout = erb_pkg::LCR_UNDEF;
        else
          st_nxt.dout = rd_word;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array write, kept out of the struct to stay a memory
  always_ff @(posedge i_core_clk) begin
    if (gate_en && st_r.wen) begin
      for (int m = 0; m < NM; m++) begin
        if (i_shape == erb_pkg::ERB_SHAPE_32X20) begin
          mod_mem[m][{st_r.waddr[4:0], 1'b0}] <= st_r.din[2*m];
          mod_mem[m][{st_r.waddr[4:0], 1'b1}] <= st_r.din[2*m+1];
        end else begin
          mod_mem[m][st_r.waddr] <= st_r.din[m];
        end
      end
    end
  end

  assign o_rd_data = st_r.dout;
endmodule

/* design/erb_embedded_ram.sv */
// Embedded RAM top: large RAM block plus logic-cluster RAM
`timescale 1ns/1ps
module erb_embedded_ram #(
  parameter int LRB_AW = erb_pkg::LRB_AW,
  parameter int LRB_DW = erb_pkg::LRB_WIDTH
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_sys_rst,
  // Large RAM block port A
  input  wire logic                       i_lrb_a_en,
  input  wire logic                       i_lrb_a_we,
  input  wire logic [LRB_AW-1:0]          i_lrb_a_addr,
  input  wire logic [LRB_DW-1:0]          i_lrb_a_wdata,
  output logic      [LRB_DW-1:0]          o_lrb_a_rdata,
  // Large RAM block port B
  input  wire logic                       i_lrb_b_en,
  input  wire logic                       i_lrb_b_we,
  input  wire logic [LRB_AW-1:0]          i_lrb_b_addr,
  input  wire logic [LRB_DW-1:0]          i_lrb_b_wdata,
  output logic      [LRB_DW-1:0]          o_lrb_b_rdata,
  // Logic-cluster RAM
  input  wire logic                       i_cluster_clock_gate_one,
  input  wire erb_pkg::erb_shape_t        i_lcr_shape,
  input  wire logic                       i_lcr_wr_en,
  input  wire logic [erb_pkg::LCR_AW-1:0] i_lcr_wr_addr,
  input  wire logic [erb_pkg::LCR_DW-1:0] i_lcr_wr_data,
  input  wire logic                       i_lcr_rd_en,
  input  wire logic [erb_pkg::LCR_AW-1:0] i_lcr_rd_addr,
  output logic      [erb_pkg::LCR_DW-1:0] o_lcr_rd_data,
  // Logic-module adder and cluster power
  input  wire logic                       i_adder_used,
  input  wire logic [LRB_DW-1:0]          i_adder_a,
  input  wire logic [LRB_DW-1:0]          i_adder_b,
  output logic      [LRB_DW-1:0]          o_adder_sum,
  input  wire erb_pkg::erb_pwr_t          i_pwr_mode,
  output logic                            o_low_power
);
  localparam int DEPTH = 1 << LRB_AW;

  typedef struct packed {
    logic [LRB_DW-1:0] a_q;
    logic [LRB_DW-1:0] b_q;
    logic [LRB_DW-1:0] lcr_q;
    logic [LRB_DW-1:0] add_a;
    logic [LRB_DW-1:0] add_b;
    logic [LRB_DW-1:0] sum;
    logic              lowp;
  } erb_top_st_t;

  erb_top_st_t st_r;
  erb_top_st_t st_nxt;
  // 20 Kb when depth times width is 1024 x 20
  logic [LRB_DW-1:0] lrb_mem [DEPTH];
  logic [erb_pkg::LCR_DW-1:0] lcr_rd;
  logic both_hit;

  // Double write to one word: A wins here, but user must avoid it
  assign both_hit = i_lrb_a_en && i_lrb_a_we && i_lrb_b_en &&
                    i_lrb_b_we && (i_lrb_a_addr == i_lrb_b_addr);

  always_ff @(posedge i_core_clk) begin
    if (i_lrb_a_en && i_lrb_a_we) begin
      lrb_mem[i_lrb_a_addr] <= i_lrb_a_wdata;
    end
    if (i_lrb_b_en && i_lrb_b_we && !both_hit) begin
      lrb_mem[i_lrb_b_addr] <= i_lrb_b_wdata;
    end
  end

  always_comb begin
    st_nxt = st_r;
    // Same-port write returns new data, per port
    if (i_lrb_a_en) begin
      st_nxt.a_q = i_lrb_a_we ? i_lrb_a_wdata
                              : lrb_mem[i_lrb_a_addr];
    end
    if (i_lrb_b_en) begin
      st_nxt.b_q = i_lrb_b_we ? i_lrb_b_wdata
                              : lrb_mem[i_lrb_b_addr];
    end
    // Mixed-port read of a word being written: shown as zero
    if (i_lrb_a_en && !i_lrb_a_we && i_lrb_b_en && i_lrb_b_we &&
        i_lrb_a_addr == i_lrb_b_addr) begin
      st_nxt.a_q = '0;
    end
    if (i_lrb_b_en && !i_lrb_b_we && i_lrb_a_en && i_lrb_a_we &&
        i_lrb_a_addr == i_lrb_b_addr) begin
      st_nxt.b_q = '0;
    end
    st_nxt.lcr_q = lcr_rd;
    // Unused adder sees constant zero, so nothing toggles
    st_nxt.add_a = i_adder_used ? i_adder_a : '0;
    st_nxt.add_b = i_adder_used ? i_adder_b : '0;
    st_nxt.sum   = st_r.add_a + st_r.add_b;
    st_nxt.lowp  = (i_pwr_mode == erb_pkg::ERB_PWR_LOW);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  erb_cluster_ram u_lcr (
    .i_core_clk               (i_core_clk),
    .i_sys_rst                (i_sys_rst),
    .i_cluster_clock_gate_one (i_cluster_clock_gate_one),
    .i_shape                  (i_lcr_shape),
    .i_wr_en                  (i_lcr_wr_en),
    .i_wr_addr                (i_lcr_wr_addr),
    .i_wr_data                (i_lcr_wr_data),
    .i_rd_en                  (i_lcr_rd_en),
    .i_rd_addr                (i_lcr_rd_addr),
    .o_rd_data                (lcr_rd)
  );

  assign o_lrb_a_rdata = st_r.a_q;
  assign o_lrb_b_rdata = st_r.b_q;
  assign o_lcr_rd_data = st_r.lcr_q;
  assign o_adder_sum   = st_r.sum;
  assign o_low_power   = st_r.lowp;
endmodule

/* dv/erb_props.sv */
// Checker: port timing of the embedded RAM top
`timescale 1ns/1ps
module erb_props #(
  parameter int LRB_AW = 10,
  parameter int LRB_DW = 20
) (
  input wire logic                       i_core_clk, i_sys_rst,
  input wire logic                       i_lrb_a_en, i_lrb_a_we,
  input wire logic                       i_lrb_b_en, i_lrb_b_we,
  input wire logic                       i_cluster_clock_gate_one,
  input wire logic                       i_adder_used, o_low_power,
  input wire logic [LRB_AW-1:0]          i_lrb_a_addr, i_lrb_b_addr,
  input wire logic [LRB_DW-1:0]          i_lrb_a_wdata, o_lrb_a_rdata,
  input wire logic [LRB_DW-1:0]          o_lrb_b_rdata, o_adder_sum,
  input wire logic [LRB_DW-1:0]          i_adder_a, i_adder_b,
  input wire logic [erb_pkg::LCR_DW-1:0] o_lcr_rd_data,
  input wire erb_pkg::erb_pwr_t          i_pwr_mode
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic addr_same = i_lrb_a_addr == i_lrb_b_addr;
  sequence s_a_wr;
    i_lrb_a_en && i_lrb_a_we;
  endsequence
  // Port B must not write or the reread could be shown as zero
  sequence s_a_reread;
    i_lrb_a_en && !i_lrb_a_we && !i_lrb_b_we && $stable(i_lrb_a_addr);
  endsequence
  AST_A_NEW: assert property (s_a_wr |=>
    o_lrb_a_rdata == $past(i_lrb_a_wdata)) else $error("A new data");
  AST_A_BACK: assert property (s_a_wr ##1 s_a_reread |=>
    o_lrb_a_rdata == $past(i_lrb_a_wdata, 2)) else $error("A readback");
  AST_MIXED: assert property (i_lrb_a_en && !i_lrb_a_we && addr_same
    && i_lrb_b_en && i_lrb_b_we |=> o_lrb_a_rdata == '0)
    else $error("A mixed read");
  AST_RST: assert property ($fell(i_sys_rst) |->
    o_lrb_a_rdata == '0 && o_lrb_b_rdata == '0 && o_lcr_rd_data == '0)
    else $error("reset outputs");
  AST_ADD_SUM: assert property (i_adder_used |-> ##2
    o_adder_sum == $past(i_adder_a, 2) + $past(i_adder_b, 2))
    else $error("adder sum");
  AST_ADD_IDLE: assert property (!i_adder_used |-> ##2
    o_adder_sum == '0) else $error("adder idle");
  AST_PWR: assert property (1'b1 |=>
    o_low_power == ($past(i_pwr_mode) == erb_pkg::ERB_PWR_LOW))
    else $error("power mode");
  AST_GATE: assert property (!i_cluster_clock_gate_one [*2] |=>
    $stable(o_lcr_rd_data)) else $error("gate freeze");
endmodule
bind erb_embedded_ram erb_props #(.LRB_AW(LRB_AW), .LRB_DW(LRB_DW))
  erb_props_i (.*);

/* dv/erb_user_model.sv */
// User-logic model: keeps the large-block ports from both writing one word
`timescale 1ns/1ps
module erb_user_model (
  input  wire logic       i_a_en,
  input  wire logic       i_a_we,
  input  wire logic [9:0] i_a_addr,
  input  wire logic       i_b_we_req,
  input  wire logic [9:0] i_b_addr,
  output logic            o_b_we
);
  // Port B yields, else the design keeps port A's word and drops B's write
  assign o_b_we = i_b_we_req
    && !(i_a_en && i_a_we && i_a_addr == i_b_addr);
endmodule

/* dv/test_embedded_ram_block_behaviour.sv */
// Testbench: embedded RAM top driven through a user-logic model
`timescale 1ns/1ps
module test_embedded_ram_block_behaviour;
  logic i_core_clk = 1'h0, i_sys_rst = 1'h1, b_we_req = 1'h0;
  logic i_lrb_a_en = 1'h0, i_lrb_a_we = 1'h0, i_lrb_b_en = 1'h0;
  wire logic i_lrb_b_we;
  logic [9:0] i_lrb_a_addr = 10'h0, i_lrb_b_addr = 10'h0;
  logic [19:0] i_lrb_a_wdata = 20'h0, i_lrb_b_wdata = 20'h0;
  logic [19:0] i_lcr_wr_data = 20'h0, i_adder_a = 20'h0, i_adder_b = 20'h0;
  logic [19:0] o_lrb_a_rdata, o_lrb_b_rdata, o_lcr_rd_data, o_adder_sum;
  logic [5:0] i_lcr_wr_addr = 6'h0, i_lcr_rd_addr = 6'h0;
  logic i_cluster_clock_gate_one = 1'h1, i_lcr_wr_en = 1'h0;
  logic i_lcr_rd_en = 1'h0, i_adder_used = 1'h0, o_low_power;
  erb_pkg::erb_shape_t i_lcr_shape = erb_pkg::ERB_SHAPE_32X20;
  erb_pkg::erb_pwr_t i_pwr_mode = erb_pkg::ERB_PWR_HIGH_PERF;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  erb_embedded_ram erb_embedded_ram_i (.*);
  erb_user_model erb_user_model_i (
    .i_a_en(i_lrb_a_en), .i_a_we(i_lrb_a_we), .i_a_addr(i_lrb_a_addr),
    .i_b_we_req(b_we_req), .i_b_addr(i_lrb_b_addr), .o_b_we(i_lrb_b_we));
  initial forever #5 i_core_clk = ~i_core_clk;
  // The run needs under 100 cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Both ports enabled over one edge; left enabled for back to back use
  task automatic lrb_op(input logic aw, input logic [9:0] aa,
      input logic [19:0] ad, input logic bw, input logic [9:0] ba,
      input logic [19:0] bd);
    {i_lrb_a_en, i_lrb_a_we, i_lrb_a_addr, i_lrb_a_wdata} = {1'h1, aw, aa, ad};
    {i_lrb_b_en, b_we_req, i_lrb_b_addr, i_lrb_b_wdata} = {1'h1, bw, ba, bd};
    cyc(1);
  endtask
  task automatic t_lrb();
    lrb_op(1'h1, 10'h3FF, 20'hA5A5A, 1'h1, 10'h0, 20'h5A5A5);
    chk("a_rdata", 20'hA5A5A, o_lrb_a_rdata);
    chk("b_rdata", 20'h5A5A5, o_lrb_b_rdata);
    lrb_op(1'h0, 10'h0, 20'h0, 1'h0, 10'h3FF, 20'h0);
    chk("a_rdata", 20'h5A5A5, o_lrb_a_rdata);
    chk("b_rdata", 20'hA5A5A, o_lrb_b_rdata);
    lrb_op(1'h1, 10'h155, 20'h12345, 1'h1, 10'h155, 20'hFEDCB);
    chk("b_rdata", 20'h0, o_lrb_b_rdata);
    lrb_op(1'h0, 10'h155, 20'h0, 1'h0, 10'h0, 20'h0);
    chk("a_rdata", 20'h12345, o_lrb_a_rdata);
    lrb_op(1'h0, 10'h155, 20'h0, 1'h1, 10'h155, 20'h0F0F0);
    chk("a_rdata", 20'h0, o_lrb_a_rdata);
    lrb_op(1'h0, 10'h155, 20'h0, 1'h0, 10'h155, 20'h0);
    chk("a_rdata", 20'h0F0F0, o_lrb_a_rdata);
    {i_lrb_a_en, i_lrb_b_en} = 2'h0;
  endtask
  task automatic lcr_rw(input erb_pkg::erb_shape_t s, input logic [5:0] a,
      input logic [19:0] d, input logic [19:0] exp);
    i_lcr_shape = s;
    {i_lcr_wr_en, i_lcr_wr_addr, i_lcr_wr_data} = {1'h1, a, d};
    cyc(1);
    i_lcr_wr_en = 1'h0;
    cyc(1);
    {i_lcr_rd_en, i_lcr_rd_addr} = {1'h1, a};
    cyc(1);
    i_lcr_rd_en = 1'h0;
    cyc(3);
    chk("lcr_rd_data", exp, o_lcr_rd_data);
  endtask
  task automatic t_lcr();
    lcr_rw(erb_pkg::ERB_SHAPE_32X20, 6'h1F, 20'hABCDE, 20'hABCDE);
    lcr_rw(erb_pkg::ERB_SHAPE_64X10, 6'h3F, 20'hFF3C5, 20'h003C5);
    {i_cluster_clock_gate_one, i_lcr_rd_en, i_lcr_rd_addr} = 8'h5F;
    cyc(4);
    chk("lcr_rd_data", 20'h003C5, o_lcr_rd_data);
    {i_cluster_clock_gate_one, i_lcr_rd_en} = 2'h2;
  endtask
  task automatic t_side();
    {i_adder_used, i_adder_a, i_adder_b} = {1'h1, 20'hFFFFF, 20'h00002};
    cyc(2);
    chk("adder_sum", 20'h00001, o_adder_sum);
    i_adder_used = 1'h0;
    cyc(2);
    chk("adder_sum", 20'h0, o_adder_sum);
    for (int m = 0; m < 2; m++) begin
      i_pwr_mode = erb_pkg::erb_pwr_t'(m);
      cyc(1);
      chk("low_power", 20'(m), {19'h0, o_low_power});
    end
  endtask
  initial begin
    cyc(4);
    i_sys_rst = 1'h0;
    cyc(1);
    chk("a_rdata", 20'h0, o_lrb_a_rdata);
    t_lrb();
    t_lcr();
    t_side();
    end_of_test();
  end
endmodule
